// *** spc_pkg.sv ***
package spc_pkg;
  localparam logic [7:0] SPC_ADDR_GATE = 8'h20;
  localparam logic [7:0] SPC_ADDR_SLEEP = 8'h35;
  localparam logic [7:0] SPC_RST_GATE = 8'h00;
  localparam logic [7:0] SPC_RST_SLEEP = 8'h00;
  localparam int SPC_BIT_BOFF = 7;
  localparam int SPC_BIT_PULLUP = 6;
  localparam int SPC_BIT_SE = 5;
  localparam int SPC_BIT_SM_HI = 4;
  localparam int SPC_BIT_SM_LO = 3;
  localparam int SPC_BIT_UNLOCK = 2;
  localparam int SPC_BIT_T1 = 3;
  localparam int SPC_BIT_T0 = 2;
  localparam int SPC_BIT_SER = 1;
  localparam int SPC_BIT_ADC = 0;
  localparam logic [3:0] SPC_GATE_MASK = 4'hf;
  localparam logic [2:0] SPC_UNLOCK_CYC = 3'h4;
  localparam logic [2:0] SPC_ACT_DELAY = 3'h3;
  localparam logic [2:0] SPC_ACT_HOLD = 3'h3;
  typedef enum logic [1:0] {
    SPC_MODE_IDLE = 2'h0,
    SPC_MODE_QUIET = 2'h1,
    SPC_MODE_PDOWN = 2'h2,
    SPC_MODE_RSVD = 2'h3
  } spc_mode_t;
  typedef enum logic [1:0] {SPC_B_IDLE, SPC_B_UNLOCKED, SPC_B_WAIT, SPC_B_ACTIVE} spc_bstate_t;
endpackage

// *** spc_clk_gate.sv ***
`timescale 1ns/1ps
module spc_clk_gate (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic gate,
  output logic clk_en
);
  // Gate takes effect only at a clock edge
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      clk_en <= 1'b1;
    end else begin
      clk_en <= ~gate;
    end
  end
endmodule

// *** spc_bod_seq.sv ***
`timescale 1ns/1ps
module spc_bod_seq
  import spc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic enable,
  input wire logic wr_ctl,
  input wire logic wr_boff,
  input wire logic wr_unlock,
  output logic unlock_q,
  output logic set_q,
  output logic active_q
);
  spc_bstate_t st_q;
  logic [2:0] cnt_q;
  always_ff @(posedge sys_clk) begin
    if (!reset_n || !enable) begin
      st_q <= SPC_B_IDLE;
      cnt_q <= 3'h0;
    end else begin
      unique case (st_q)
        SPC_B_IDLE: begin
          if (wr_ctl && wr_boff && wr_unlock) begin
            st_q <= SPC_B_UNLOCKED;
            cnt_q <= 3'h0;
          end
        end
        SPC_B_UNLOCKED: begin
          if (wr_ctl && wr_boff && !wr_unlock) begin
            st_q <= SPC_B_WAIT;
            cnt_q <= 3'h1;
          end else if (cnt_q == SPC_UNLOCK_CYC - 3'h1) begin
            st_q <= SPC_B_IDLE;
          end else begin
            cnt_q <= cnt_q + 3'h1;
          end
        end
        SPC_B_WAIT: begin
          if (cnt_q == SPC_ACT_DELAY) begin
            st_q <= SPC_B_ACTIVE;
            cnt_q <= 3'h1;
          end else begin
            cnt_q <= cnt_q + 3'h1;
          end
        end
        SPC_B_ACTIVE: begin
          if (cnt_q == SPC_ACT_HOLD) begin
            st_q <= SPC_B_IDLE;
          end else begin
            cnt_q <= cnt_q + 3'h1;
          end
        end
      endcase
    end
  end
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      unlock_q <= 1'b0;
      set_q <= 1'b0;
      active_q <= 1'b0;
    end else begin
      unlock_q <= 1'b0;
      set_q <= 1'b0;
      active_q <= 1'b0;
      if (enable) begin
        unlock_q <= (st_q == SPC_B_IDLE && wr_ctl && wr_boff && wr_unlock) ||
                    (st_q == SPC_B_UNLOCKED && !(wr_ctl && wr_boff && !wr_unlock) &&
                     cnt_q != SPC_UNLOCK_CYC - 3'h1);
        set_q <= (st_q == SPC_B_UNLOCKED && wr_ctl && wr_boff && !wr_unlock) ||
                 (st_q == SPC_B_WAIT) || (st_q == SPC_B_ACTIVE && cnt_q != SPC_ACT_HOLD);
        active_q <= (st_q == SPC_B_WAIT && cnt_q == SPC_ACT_DELAY) ||
                    (st_q == SPC_B_ACTIVE && cnt_q != SPC_ACT_HOLD);
      end
    end
  end
endmodule

// *** spc_top.sv ***
// Design decision made here: strobed register access.
`timescale 1ns/1ps
module spc_top
  import spc_pkg::*;
#(
  parameter bit HAS_SLEEP_BOD = 1'b1
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic sleep_instr,
  input wire logic wake_event,
  input wire logic adc_enable,
  input wire logic acmp_enable,
  input wire logic acmp_uses_ref,
  input wire logic wdt_enable,
  input wire logic brownout_level_fuses,
  input wire logic [5:0] wake_pin_mask,
  output logic sleeping,
  output logic [1:0] sleep_mode,
  output logic pullup_disable,
  output logic [1:0] int_sense,
  output logic timer_one_clk_en,
  output logic timer_zero_clk_en,
  output logic serial_iface_clk_en,
  output logic adc_clk_en,
  output logic adc_run,
  output logic adc_extended_next,
  output logic acmp_run,
  output logic internal_ref_on,
  output logic brownout_detector_on,
  output logic wdt_run,
  output logic [5:0] input_buffer_en
);
  logic [7:0] ctl_q;
  logic [3:0] gate_q;
  logic wr_ctl;
  logic wr_gate;
  logic boff_unlock;
  logic boff_set;
  logic boff_active;
  logic bod_off_q;
  logic sleeping_q;
  logic [1:0] mode_q;
  logic adc_was_on_q;
  logic ext_q;
  logic pdown;
  logic bufs_off;
  logic acmp_on;
  logic adc_on;
  logic t1_en;
  logic t0_en;
  logic ser_en;
  logic adc_en;

  assign wr_ctl = reg_wr && (reg_addr == SPC_ADDR_SLEEP);
  assign wr_gate = reg_wr && (reg_addr == SPC_ADDR_GATE);

  // Control bits other than the timed pair
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      ctl_q <= SPC_RST_SLEEP;
    end else if (wr_ctl) begin
      ctl_q <= reg_wdata;
    end
  end

  // Clock gate register
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      gate_q <= SPC_RST_GATE[3:0];
    end else if (wr_gate) begin
      gate_q <= reg_wdata[3:0] & SPC_GATE_MASK;
    end
  end

  spc_bod_seq u_seq (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .enable(HAS_SLEEP_BOD),
    .wr_ctl(wr_ctl),
    .wr_boff(reg_wdata[SPC_BIT_BOFF]),
    .wr_unlock(reg_wdata[SPC_BIT_UNLOCK]),
    .unlock_q(boff_unlock),
    .set_q(boff_set),
    .active_q(boff_active)
  );

  spc_clk_gate u_g_t1 (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .gate(gate_q[SPC_BIT_T1]),
    .clk_en(t1_en)
  );
  spc_clk_gate u_g_t0 (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .gate(gate_q[SPC_BIT_T0]),
    .clk_en(t0_en)
  );
  spc_clk_gate u_g_ser (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .gate(gate_q[SPC_BIT_SER]),
    .clk_en(ser_en)
  );
  spc_clk_gate u_g_adc (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .gate(gate_q[SPC_BIT_ADC]),
    .clk_en(adc_en)
  );

  // Register read, one cycle later
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      if (reg_addr == SPC_ADDR_SLEEP) begin
        reg_rdata <= ctl_q;
        reg_rdata[SPC_BIT_BOFF] <= HAS_SLEEP_BOD & boff_set;
        reg_rdata[SPC_BIT_UNLOCK] <= HAS_SLEEP_BOD & boff_unlock;
      end else if (reg_addr == SPC_ADDR_GATE) begin
        reg_rdata <= {4'h0, gate_q};
      end else begin
        reg_rdata <= 8'h00;
      end
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // Sleep entry and exit
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      sleeping_q <= 1'b0;
      mode_q <= 2'h0;
      bod_off_q <= 1'b0;
    end else if (sleeping_q) begin
      if (wake_event) begin
        sleeping_q <= 1'b0;
        bod_off_q <= 1'b0;
      end
    end else if (sleep_instr && ctl_q[SPC_BIT_SE] &&
                 ctl_q[SPC_BIT_SM_HI:SPC_BIT_SM_LO] != SPC_MODE_RSVD) begin
      sleeping_q <= 1'b1;
      mode_q <= ctl_q[SPC_BIT_SM_HI:SPC_BIT_SM_LO];
      bod_off_q <= boff_active;
    end
  end

  assign pdown = sleeping_q && (mode_q == SPC_MODE_PDOWN);
  // Input buffers off in power-down except wake_pin_mask pins; converter clock not stopped
  assign bufs_off = pdown;
  assign acmp_on = acmp_enable && !gate_q[SPC_BIT_ADC] && (!pdown || acmp_uses_ref);
  assign adc_on = adc_enable && !gate_q[SPC_BIT_ADC];

  // Converter first-conversion tracking
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      adc_was_on_q <= 1'b0;
      ext_q <= 1'b1;
    end else begin
      adc_was_on_q <= adc_on;
      // Extended after re-enable
      // Held while off and through the first cycle on
      if (!adc_on || !adc_was_on_q) begin
        ext_q <= 1'b1;
      end else begin
        ext_q <= 1'b0;
      end
    end
  end

  // Output registers
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      sleeping <= 1'b0;
      sleep_mode <= 2'h0;
      pullup_disable <= 1'b0;
      int_sense <= 2'h0;
      timer_one_clk_en <= 1'b1;
      timer_zero_clk_en <= 1'b1;
      serial_iface_clk_en <= 1'b1;
      adc_clk_en <= 1'b1;
      adc_run <= 1'b0;
      adc_extended_next <= 1'b1;
      acmp_run <= 1'b0;
      internal_ref_on <= 1'b0;
      brownout_detector_on <= 1'b0;
      wdt_run <= 1'b0;
      input_buffer_en <= 6'h3f;
    end else begin
      sleeping <= sleeping_q;
      sleep_mode <= ctl_q[SPC_BIT_SM_HI:SPC_BIT_SM_LO];
      pullup_disable <= ctl_q[SPC_BIT_PULLUP];
      int_sense <= ctl_q[1:0];
      timer_one_clk_en <= t1_en;
      timer_zero_clk_en <= t0_en;
      serial_iface_clk_en <= ser_en;
      adc_clk_en <= adc_en;
      adc_run <= adc_on;
      adc_extended_next <= ext_q;
      acmp_run <= acmp_on;
      brownout_detector_on <= brownout_level_fuses && !(sleeping_q && bod_off_q);
      internal_ref_on <= (brownout_level_fuses && !(sleeping_q && bod_off_q)) ||
                         (acmp_on && acmp_uses_ref) || adc_on;
      wdt_run <= wdt_enable;
      input_buffer_en <= bufs_off ? wake_pin_mask : 6'h3f;
    end
  end
endmodule

// *** spc_top_asserts.sv ***
`timescale 1ns/1ps
module spc_top_asserts
  import spc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic sleep_instr,
  input wire logic adc_enable,
  input wire logic wdt_enable,
  input wire logic [5:0] wake_pin_mask,
  input wire logic sleeping,
  input wire logic [1:0] sleep_mode,
  input wire logic timer_one_clk_en,
  input wire logic adc_clk_en,
  input wire logic adc_run,
  input wire logic acmp_run,
  input wire logic internal_ref_on,
  input wire logic wdt_run,
  input wire logic [5:0] input_buffer_en
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);
  chk_gate_rsvd: assert property ($past(reg_rd) && $past(reg_addr) == SPC_ADDR_GATE
    |-> reg_rdata[7:4] == 4'h0) else $error("gate reserved bits");
  chk_timer_gate: assert property (reg_wr && reg_addr == SPC_ADDR_GATE
    && reg_wdata[SPC_BIT_T1] |-> ##3 !timer_one_clk_en) else $error("timer one not gated");
  chk_adc_gate: assert property (reg_wr && reg_addr == SPC_ADDR_GATE
    && reg_wdata[SPC_BIT_ADC] |-> ##2 !acmp_run ##1 !adc_clk_en) else $error("adc not gated");
  chk_sleep_cause: assert property ($rose(sleeping) |-> $past(sleep_instr, 2))
    else $error("sleep without instruction");
  chk_mode_rsvd: assert property ($rose(sleeping) |-> sleep_mode != 2'h3)
    else $error("reserved mode slept");
  chk_buf_pdown: assert property (sleeping && $past(sleeping) && sleep_mode == 2'h2
    |-> input_buffer_en == wake_pin_mask) else $error("buffers in power-down");
  chk_adc_stays: assert property ($past(reset_n) && adc_enable && $past(adc_enable)
    && adc_clk_en && $past(adc_clk_en) |-> adc_run) else $error("adc stopped");
  chk_wdt_runs: assert property ($past(reset_n) && wdt_enable && $past(wdt_enable)
    |-> wdt_run) else $error("watchdog stopped");
  chk_ref_adc: assert property ($past(reset_n) && adc_enable && $past(adc_enable)
    |-> internal_ref_on) else $error("reference off");
  cover property ($rose(sleeping));
  cover property (sleeping && sleep_mode == 2'h2);
  cover property (!adc_clk_en);
endmodule

bind spc_top spc_top_asserts i_chk (.*);

// *** sleep_power_control_tb.sv ***
`timescale 1ns/1ps
module sleep_power_control_tb;
  import spc_pkg::*;
  logic sys_clk, reset_n, reg_wr, reg_rd, sleep_instr, wake_event, adc_enable, acmp_enable;
  logic acmp_uses_ref, wdt_enable, brownout_level_fuses, sleeping, pullup_disable, adc_run;
  logic timer_one_clk_en, timer_zero_clk_en, serial_iface_clk_en, adc_clk_en, acmp_run;
  logic adc_extended_next, internal_ref_on, brownout_detector_on, wdt_run;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, exp_v;
  logic [5:0] wake_pin_mask, input_buffer_en;
  logic [1:0] sleep_mode, int_sense;
  int bad_count = 0;
  int n_compared = 0;
  int cycles = 0;
  // Address, write data, read-back value
  logic [23:0] rows [6] = '{24'h357b7b, 24'h35fb7b, 24'h20ff0f, 24'h20a505, 24'h44ff00,
    24'h350000};
  logic [7:0] gates [3] = '{8'h05, 8'h0f, 8'h00};

  spc_top #(.HAS_SLEEP_BOD(1'b1)) i_dut (.*);

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 2000) begin
      bad_count++;
      $display("unexpected at %0t: run too long", $time);
      end_of_test();
    end
  end

  task automatic cmp(input logic [7:0] got, input logic [7:0] e);
    n_compared++;
    if (got !== e) begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, e);
    end
  endtask

  task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
    reg_wr <= w;
    reg_rd <= r;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
  endtask

  task automatic idle(input int n);
    repeat (n) bus(1'b0, 1'b0, 8'h00, 8'h00);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    bus(1'b0, 1'b1, a, 8'h00);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    cmp(reg_rdata, e);
    @(posedge sys_clk);
  endtask

  task automatic doze;
    sleep_instr <= 1'b1;
    idle(1);
    sleep_instr <= 1'b0;
    idle(2);
    @(negedge sys_clk);
  endtask

  task automatic wake;
    @(posedge sys_clk);
    wake_event <= 1'b1;
    idle(1);
    wake_event <= 1'b0;
    idle(3);
  endtask

  initial begin
    {reset_n, reg_wr, reg_rd, sleep_instr, wake_event, adc_enable, acmp_uses_ref} = '0;
    {reg_addr, reg_wdata} = '0;
    {wdt_enable, acmp_enable, brownout_level_fuses} = 3'b011;
    wake_pin_mask = 6'h05;
    repeat (3) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(negedge sys_clk);
    cmp({timer_one_clk_en, timer_zero_clk_en, serial_iface_clk_en, adc_clk_en,
      adc_extended_next, sleeping, wdt_run, 1'b0}, 8'hf8);
    cmp({2'b00, input_buffer_en}, 8'h3f);
    @(posedge sys_clk);
    rd(SPC_ADDR_SLEEP, SPC_RST_SLEEP);
    rd(SPC_ADDR_GATE, SPC_RST_GATE);
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      bus(1'b1, 1'b0, rows[i][23:16], rows[i][15:8]);
      rd(rows[i][23:16], rows[i][7:0]);
    end
    bus(1'b1, 1'b0, SPC_ADDR_SLEEP, 8'h7b);
    idle(1);
    @(negedge sys_clk);
    cmp({3'h0, pullup_disable, sleep_mode, int_sense}, 8'h1f);
    @(posedge sys_clk);
    $display("test table done");
    for (int j = 0; j < 3; j++) begin
      bus(1'b1, 1'b0, SPC_ADDR_GATE, gates[j]);
      idle(3);
      @(negedge sys_clk);
      cmp({4'h0, timer_one_clk_en, timer_zero_clk_en, serial_iface_clk_en, adc_clk_en},
        {4'h0, ~gates[j][3:0]});
      cmp({7'h00, acmp_run}, {7'h00, ~gates[j][0]});
      @(posedge sys_clk);
    end
    $display("test gating done");
    adc_enable <= 1'b1;
    wdt_enable <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      bus(1'b1, 1'b0, SPC_ADDR_SLEEP, {2'b00, i < 4, (i == 4) ? 2'h2 : i[1:0], 3'b000});
      doze();
      exp_v = {2'b00, i < 3, 1'b1, i != 2, 3'b111};
      cmp({2'b00, sleeping, brownout_detector_on, acmp_run, adc_run, wdt_run,
        internal_ref_on}, exp_v);
      cmp({2'b00, input_buffer_en}, (i == 2) ? 8'h05 : 8'h3f);
      cmp({7'h00, adc_extended_next}, 8'h00);
      wake();
    end
    $display("test modes done");
    bus(1'b1, 1'b0, SPC_ADDR_SLEEP, 8'h84);
    idle(5);
    bus(1'b1, 1'b0, SPC_ADDR_SLEEP, 8'h80);
    rd(SPC_ADDR_SLEEP, 8'h00);
    bus(1'b1, 1'b0, SPC_ADDR_SLEEP, 8'hb4);
    bus(1'b1, 1'b0, SPC_ADDR_SLEEP, 8'hb0);
    rd(SPC_ADDR_SLEEP, 8'hb0);
    idle(1);
    doze();
    cmp({6'h00, sleeping, brownout_detector_on}, 8'h02);
    wake();
    @(negedge sys_clk);
    cmp({7'h00, brownout_detector_on}, 8'h01);
    @(posedge sys_clk);
    rd(SPC_ADDR_SLEEP, 8'h30);
    $display("test detector sequence done");
    bus(1'b1, 1'b0, SPC_ADDR_GATE, 8'h0e);
    bus(1'b1, 1'b0, SPC_ADDR_SLEEP, 8'h84);
    reset_n <= 1'b0;
    idle(3);
    reset_n <= 1'b1;
    @(negedge sys_clk);
    cmp({timer_one_clk_en, timer_zero_clk_en, serial_iface_clk_en, adc_clk_en,
      adc_extended_next, sleeping, wdt_run, 1'b0}, 8'hf8);
    cmp({2'b00, input_buffer_en}, 8'h3f);
    @(posedge sys_clk);
    rd(SPC_ADDR_GATE, SPC_RST_GATE);
    rd(SPC_ADDR_SLEEP, SPC_RST_SLEEP);
    $display("test mid-run reset done");
    end_of_test();
  end
endmodule
